// *** src/dma_pkg.sv ***
/*
 * Constants and types shared by the two-channel DMA controller.
 * Assumes a byte-addressed register port with 32-bit word registers.
 */
package dma_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets: per-channel window registers, stride and global priority
    localparam logic [7:0] OFF_CTRL   = 8'h00;  // Control word
    localparam logic [7:0] OFF_SRC    = 8'h04;  // Source address
    localparam logic [7:0] OFF_DST    = 8'h08;  // Destination address
    localparam logic [7:0] OFF_COUNT  = 8'h0c;  // Transfers minus one
    localparam logic [7:0] OFF_STATUS = 8'h10;  // Done, error, busy
    localparam logic [7:0] OFF_SWREQ  = 8'h14;  // Software request
    localparam logic [7:0] CH_STRIDE  = 8'h20;  // Window per channel
    localparam logic [7:0] OFF_PRIO   = 8'h40;  // Global priority mode

    ////////////////////////////////////////////////////////////////////////
    // Control word field positions
    localparam int CTRL_EN     = 0;  // Arm the channel
    localparam int CTRL_SIZE_L = 1;  // Unit size, two bits
    localparam int CTRL_SRC_IO = 3;  // Source stays fixed
    localparam int CTRL_DST_IO = 4;  // Destination stays fixed
    localparam int CTRL_BURST  = 5;  // Hold bus for whole job
    localparam int CTRL_EXT    = 6;  // Accept external request
    localparam int CTRL_MASK   = 7;  // Mask interrupt output

    // Status field positions
    localparam int STAT_DONE = 0;  // Job complete, write one clears
    localparam int STAT_ERR  = 1;  // Error seen, write one clears
    localparam int STAT_BUSY = 2;  // Job in progress

    ////////////////////////////////////////////////////////////////////////
    // Transfer unit sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // Reset values
    localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
    localparam logic [15:0] RESET_COUNT = 16'h0000;

    // Transfer engine states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQ,
        ST_READ,
        ST_WRITE
    } eng_state_type;

endpackage : dma_pkg

// *** src/two_channel_dma_controller.sv ***
/*
 * Two-channel DMA controller: register port, arbiter, transfer engine.
 * Assumes a bus arbiter that holds grant while request stays high, and a
 * memory port that answers each read or write strobe with an ack.
 */
`timescale 1ns/10ps

//
// Behaviour
// - two independent channels, own config, request, interrupt
// - memory or I/O on either side
// - fixed priority serves channel zero first
// - round-robin demotes the last granted channel
// - one to 65,536 transfers per job
// - byte, half-word or word units
// - cycle steal requests bus per transfer
// - burst holds bus request until job ends
// - software request bit starts a job
// - external request line starts a job
// - interrupt on job end or error
// - one interrupt output per channel
// - mask silences interrupt, flags still set
module two_channel_dma_controller #(
    parameter int CHANNELS = 2  // Channel count
) (
    input  wire logic                i_clock,      // System clock
    input  wire logic                i_srst,       // Sync reset, high
    input  wire logic [7:0]          i_reg_addr,   // Register byte address
    input  wire logic [31:0]         i_reg_wdata,  // Register write data
    input  wire logic                i_reg_wr,     // Write strobe
    input  wire logic                i_reg_rd,     // Read strobe
    output logic      [31:0]         o_reg_rdata,  // Read data, next cycle
    input  wire logic [CHANNELS-1:0] i_dreq,       // External requests
    output logic      [CHANNELS-1:0] o_irq,        // Interrupt per channel
    output logic                     o_bus_req,    // System bus request
    input  wire logic                i_bus_grant,  // System bus grant
    output logic      [31:0]         o_mem_addr,   // Transfer address
    output logic                     o_mem_rd,     // Read strobe, held
    output logic                     o_mem_wr,     // Write strobe, held
    output logic      [1:0]          o_mem_size,   // Unit size
    output logic      [31:0]         o_mem_wdata,  // Write data
    input  wire logic [31:0]         i_mem_rdata,  // Read data
    input  wire logic                i_mem_ack,    // Access complete
    input  wire logic                i_mem_err     // Access failed
);

    ////////////////////////////////////////////////////////////////////////
    // State record
    // Everything the block remembers, per channel where needed
    typedef struct packed {
        logic [CHANNELS-1:0][31:0] src;     // Current source address
        logic [CHANNELS-1:0][31:0] dst;     // Current destination
        logic [CHANNELS-1:0][15:0] cnt;     // Remaining minus one
        logic [CHANNELS-1:0][1:0]  size;    // Unit size
        logic [CHANNELS-1:0]       en;      // Armed
        logic [CHANNELS-1:0]       src_io;  // Fixed source
        logic [CHANNELS-1:0]       dst_io;  // Fixed destination
        logic [CHANNELS-1:0]       burst;   // Burst mode
        logic [CHANNELS-1:0]       ext;     // External request allowed
        logic [CHANNELS-1:0]       mask;    // Interrupt mask
        logic [CHANNELS-1:0]       act;     // Job started
        logic [CHANNELS-1:0]       done;    // Job complete flag
        logic [CHANNELS-1:0]       err;     // Error flag
        logic                      rr;      // Round-robin selected
        logic                      last;    // Last granted channel
        logic                      cur;     // Channel being served
        dma_pkg::eng_state_type    state;   // Engine state
        logic [31:0]               data;    // Transfer holding word
        logic [31:0]               rdata;   // Register read data
    } dma_state_type;

    dma_state_type state_ff;      // Registered state
    dma_state_type nxt_state_ff;  // Next state

    ////////////////////////////////////////////////////////////////////////
    // Address step for one unit
    // Size 3 never gets here; the engine flags it before any access
    function automatic logic [31:0] unit_step(input logic [1:0] sz);
        unit_step = 32'h0000_0001;
        if (sz == dma_pkg::SIZE_HALF) begin
            unit_step = 32'h0000_0002;
        end else if (sz == dma_pkg::SIZE_WORD) begin
            unit_step = 32'h0000_0004;
        end
    endfunction : unit_step

    // Whether the window of channel ch holds an address
    function automatic logic chan_hit(input logic [7:0] a, input logic ch);
        logic [7:0] base;
        base = ch ? dma_pkg::CH_STRIDE : 8'h00;
        chan_hit = (a >= base) && (a < base + dma_pkg::CH_STRIDE);
    endfunction : chan_hit

    // Pick a channel among pending ones
    // Fixed mode favours channel zero; round-robin skips the last one
    function automatic logic pick(input logic [1:0] pend, input logic rr,
                                  input logic last);
        pick = 1'b0;
        if (pend == 2'h3) begin
            pick = rr ? ~last : 1'b0;
        end else if (pend[1]) begin
            pick = 1'b1;
        end
    endfunction : pick

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    // Register port first, then requests, then the engine; end of job
    // and reset come last so that they override everything above
    always_comb begin
        logic [7:0]  off;
        logic        ch;
        logic [1:0]  pend;
        logic        c;
        logic        fin;
        off  = 8'h00;
        ch   = 1'b0;
        pend = 2'h0;
        c    = state_ff.cur;
        fin  = 1'b0;
        nxt_state_ff = state_ff;
        nxt_state_ff.rdata = 32'h0000_0000;

        // Register writes
        // Channel one window sits one stride above channel zero
        ch  = chan_hit(i_reg_addr, 1'b1);
        off = i_reg_addr - (ch ? dma_pkg::CH_STRIDE : 8'h00);
        if (i_reg_wr) begin
            if (i_reg_addr == dma_pkg::OFF_PRIO) begin
                nxt_state_ff.rr = i_reg_wdata[0];
            end else if (i_reg_addr >= (dma_pkg::CH_STRIDE << 1)) begin
                // Unmapped address, write ignored
            end else if (off == dma_pkg::OFF_CTRL) begin
                // Writing a one to enable re-arms the channel
                nxt_state_ff.en[ch]     = i_reg_wdata[dma_pkg::CTRL_EN];
                nxt_state_ff.size[ch]   =
                    i_reg_wdata[dma_pkg::CTRL_SIZE_L +: 2];
                nxt_state_ff.src_io[ch] =
                    i_reg_wdata[dma_pkg::CTRL_SRC_IO];
                nxt_state_ff.dst_io[ch] =
                    i_reg_wdata[dma_pkg::CTRL_DST_IO];
                nxt_state_ff.burst[ch]  = i_reg_wdata[dma_pkg::CTRL_BURST];
                nxt_state_ff.ext[ch]    = i_reg_wdata[dma_pkg::CTRL_EXT];
                nxt_state_ff.mask[ch]   = i_reg_wdata[dma_pkg::CTRL_MASK];
                if (!i_reg_wdata[dma_pkg::CTRL_EN]) begin
                    nxt_state_ff.act[ch] = 1'b0;
                end
            end else if (off == dma_pkg::OFF_SRC) begin
                nxt_state_ff.src[ch] = i_reg_wdata;
            end else if (off == dma_pkg::OFF_DST) begin
                nxt_state_ff.dst[ch] = i_reg_wdata;
            end else if (off == dma_pkg::OFF_COUNT) begin
                nxt_state_ff.cnt[ch] = i_reg_wdata[15:0];
            end else if (off == dma_pkg::OFF_STATUS) begin
                // Write one to clear; hardware set below wins
                if (i_reg_wdata[dma_pkg::STAT_DONE]) begin
                    nxt_state_ff.done[ch] = 1'b0;
                end
                if (i_reg_wdata[dma_pkg::STAT_ERR]) begin
                    nxt_state_ff.err[ch] = 1'b0;
                end
            end else if (off == dma_pkg::OFF_SWREQ) begin
                if (i_reg_wdata[0] && state_ff.en[ch]) begin
                    nxt_state_ff.act[ch] = 1'b1;
                end
            end
        end

        // Register reads
        // Read data lands one cycle later and is zero otherwise
        if (i_reg_rd) begin
            if (i_reg_addr == dma_pkg::OFF_PRIO) begin
                nxt_state_ff.rdata = {31'h0000_0000, state_ff.rr};
            end else if (i_reg_addr >= (dma_pkg::CH_STRIDE << 1)) begin
                nxt_state_ff.rdata = 32'h0000_0000;
            end else if (off == dma_pkg::OFF_CTRL) begin
                nxt_state_ff.rdata = {24'h00_0000, state_ff.mask[ch],
                    state_ff.ext[ch], state_ff.burst[ch],
                    state_ff.dst_io[ch], state_ff.src_io[ch],
                    state_ff.size[ch], state_ff.en[ch]};
            end else if (off == dma_pkg::OFF_SRC) begin
                nxt_state_ff.rdata = state_ff.src[ch];
            end else if (off == dma_pkg::OFF_DST) begin
                nxt_state_ff.rdata = state_ff.dst[ch];
            end else if (off == dma_pkg::OFF_COUNT) begin
                nxt_state_ff.rdata = {16'h0000, state_ff.cnt[ch]};
            end else if (off == dma_pkg::OFF_STATUS) begin
                nxt_state_ff.rdata = {29'h0000_0000, state_ff.act[ch],
                    state_ff.err[ch], state_ff.done[ch]};
            end
        end

        // External requests start armed channels
        // Each channel keeps its own flags and pending bit
        for (int i = 0; i < CHANNELS; i++) begin
            if (state_ff.en[i] && state_ff.ext[i] && i_dreq[i]) begin
                nxt_state_ff.act[i] = 1'b1;
            end
            pend[i] = state_ff.en[i] && state_ff.act[i];
        end

        // Transfer engine
        // One channel is served at a time; the other stays pending
        case (state_ff.state)
            dma_pkg::ST_IDLE: begin
                if (pend != 2'h0) begin
                    nxt_state_ff.cur   = pick(pend, state_ff.rr,
                                              state_ff.last);
                    nxt_state_ff.state = dma_pkg::ST_REQ;
                end
            end
            dma_pkg::ST_REQ: begin
                // Grant edge marks this channel as last served
                if (i_bus_grant) begin
                    nxt_state_ff.last  = c;
                    nxt_state_ff.state = dma_pkg::ST_READ;
                end
            end
            dma_pkg::ST_READ: begin
                if (state_ff.size[c] > dma_pkg::SIZE_WORD) begin
                    // Illegal unit size ends the job as an error
                    nxt_state_ff.err[c] = 1'b1;
                    fin = 1'b1;
                end else if (i_mem_ack && i_mem_err) begin
                    nxt_state_ff.err[c] = 1'b1;
                    fin = 1'b1;
                end else if (i_mem_ack) begin
                    nxt_state_ff.data  = i_mem_rdata;
                    nxt_state_ff.state = dma_pkg::ST_WRITE;
                end
            end
            dma_pkg::ST_WRITE: begin
                if (i_mem_ack && i_mem_err) begin
                    nxt_state_ff.err[c] = 1'b1;
                    fin = 1'b1;
                end else if (i_mem_ack) begin
                    // Memory sides advance, I/O sides stay put
                    if (!state_ff.src_io[c]) begin
                        nxt_state_ff.src[c] = state_ff.src[c] +
                            unit_step(state_ff.size[c]);
                    end
                    if (!state_ff.dst_io[c]) begin
                        nxt_state_ff.dst[c] = state_ff.dst[c] +
                            unit_step(state_ff.size[c]);
                    end
                    if (state_ff.cnt[c] == dma_pkg::RESET_COUNT) begin
                        nxt_state_ff.done[c] = 1'b1;
                        fin = 1'b1;
                    end else begin
                        nxt_state_ff.cnt[c] = state_ff.cnt[c] - 16'h0001;
                        if (state_ff.burst[c]) begin
                            nxt_state_ff.state = dma_pkg::ST_READ;
                        end else begin
                            nxt_state_ff.state = dma_pkg::ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                nxt_state_ff.state = dma_pkg::ST_IDLE;
            end
        endcase

        // End of job disarms the channel and frees the bus
        // A disarmed channel waits until software sets enable again
        if (fin) begin
            nxt_state_ff.en[c]  = 1'b0;
            nxt_state_ff.act[c] = 1'b0;
            nxt_state_ff.state  = dma_pkg::ST_IDLE;
        end

        // Synchronous reset
        // Reset wins over every update above
        if (i_srst) begin
            nxt_state_ff = '0;
            nxt_state_ff.state = dma_pkg::ST_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    // One flop bank holds the whole record
    always_ff @(posedge i_clock) begin
        state_ff <= nxt_state_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    // Strobes decode the engine state; data comes from the record
    assign o_reg_rdata = state_ff.rdata;
    assign o_irq       = (state_ff.done | state_ff.err) &
                         ~state_ff.mask;
    assign o_bus_req   = (state_ff.state != dma_pkg::ST_IDLE);
    assign o_mem_rd    = (state_ff.state == dma_pkg::ST_READ) &&
                         (state_ff.size[state_ff.cur] <= dma_pkg::SIZE_WORD);
    assign o_mem_wr    = (state_ff.state == dma_pkg::ST_WRITE);
    assign o_mem_addr  = (state_ff.state == dma_pkg::ST_WRITE) ?
                         state_ff.dst[state_ff.cur] :
                         state_ff.src[state_ff.cur];
    assign o_mem_size  = state_ff.size[state_ff.cur];
    assign o_mem_wdata = state_ff.data;

endmodule : two_channel_dma_controller

// *** tb/dma_monitor.sv ***
/* Assertion checker for the DMA controller ports.
   Assumes binding to the controller top, one clock domain. */
`timescale 1ns/10ps
module dma_monitor (
    input wire logic        i_clock,     // System clock
    input wire logic        i_srst,      // Sync reset
    input wire logic        i_reg_rd,    // Register read strobe
    input wire logic [31:0] o_reg_rdata, // Register read data
    input wire logic        o_bus_req,   // Bus request
    input wire logic        i_bus_grant, // Bus grant
    input wire logic [31:0] o_mem_addr,  // Transfer address
    input wire logic        o_mem_rd,    // Memory read strobe
    input wire logic        o_mem_wr,    // Memory write strobe
    input wire logic [1:0]  o_mem_size,  // Unit size
    input wire logic [31:0] o_mem_wdata, // Write data
    input wire logic        i_mem_ack,   // Access done
    input wire logic        i_mem_err    // Access failed
);
    // Every check on the rising edge, reset silences all
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    ////////////////////////////////////////////////////////////////////////
    rw_excl_a:
    assert property (!(o_mem_rd && o_mem_wr)) else $error("rd and wr both");
    rd_hold_a:
    assert property (o_mem_rd && !i_mem_ack |=> o_mem_rd && $stable(o_mem_addr))
        else $error("read dropped early");
    wr_hold_a:
    assert property (o_mem_wr && !i_mem_ack |=> o_mem_wr
        && $stable(o_mem_addr) && $stable(o_mem_wdata)) else $error("bad wr");
    wr_follows_a:
    assert property (o_mem_rd && i_mem_ack && !i_mem_err |=> o_mem_wr)
        else $error("no write after read");
    err_stops_a:
    assert property (o_mem_rd && i_mem_ack && i_mem_err |=> !o_mem_wr [*2])
        else $error("write after error");
    strobe_req_a:
    assert property (o_mem_rd || o_mem_wr |-> o_bus_req)
        else $error("strobe without request");
    grant_first_a:
    assert property ($rose(o_mem_rd) |-> $past(i_bus_grant))
        else $error("read before grant");
    size_legal_a:
    assert property (o_mem_rd || o_mem_wr |-> o_mem_size != 2'h3)
        else $error("illegal size");
    rdata_idle_a:
    assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
        else $error("read data not zero");
endmodule : dma_monitor

bind two_channel_dma_controller dma_monitor u_dma_monitor (
    .i_clock(i_clock), .i_srst(i_srst), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_bus_req(o_bus_req),
    .i_bus_grant(i_bus_grant), .o_mem_addr(o_mem_addr),
    .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_size(o_mem_size),
    .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack), .i_mem_err(i_mem_err));

// *** tb/bus_partner.sv ***
/* Bus arbiter and memory model facing the DMA controller.
   Assumes strobes held until ack; i_slow and i_fail set by the bench. */
`timescale 1ns/10ps
module bus_partner (
    input wire logic        i_clock,     // System clock
    input wire logic        i_srst,      // Sync reset
    input wire logic        i_bus_req,   // Request from controller
    output logic            o_bus_grant, // Grant, follows request
    input wire logic [31:0] i_mem_addr,  // Access address
    input wire logic        i_mem_rd,    // Read strobe
    input wire logic        i_mem_wr,    // Write strobe
    output logic [31:0]     o_mem_rdata, // Read data
    output logic            o_mem_ack,   // One-cycle answer
    output logic            o_mem_err,   // Failed read
    input wire logic        i_slow,      // Three wait cycles
    input wire logic        i_fail       // Fail every read
);
    logic [1:0] wait_cnt; // Wait cycles spent
    // Pattern from address; inverse outside the ack cycle
    assign o_mem_rdata = (i_mem_addr ^ 32'h5a5a_a5a5) ^ {32{!o_mem_ack}};
    ////////////////////////////////////////////////////////////////////////
    // Grant tracks request, ack after optional waits
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_bus_grant <= 1'b0;
            o_mem_ack   <= 1'b0;
            o_mem_err   <= 1'b0;
            wait_cnt    <= 2'h0;
        end else begin
            o_bus_grant <= i_bus_req;
            o_mem_ack   <= 1'b0;
            o_mem_err   <= 1'b0;
            if (!o_mem_ack && (i_mem_rd || i_mem_wr)) begin
                if (!i_slow || wait_cnt == 2'h3) begin
                    o_mem_ack <= 1'b1;
                    o_mem_err <= i_fail && i_mem_rd;
                    wait_cnt  <= 2'h0;
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end
        end
    end
endmodule : bus_partner

// *** tb/tb.sv ***
/* Self-checking bench for the two-channel DMA controller.
   Assumes the partner model answers the bus side. */
`timescale 1ns/10ps
module tb;
    localparam logic [7:0] C1 = dma_pkg::CH_STRIDE; // Channel one base
    logic clock, srst, reg_wr, reg_rd, slow, fail, bus_req, grant;
    logic mem_rd, mem_wr, mem_ack, mem_err, req_q;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, s;
    logic [1:0]  dreq, irq, mem_size, zs; // zs: size of last write
    logic [31:0] wq[$], dq[$], rq[$]; // Write addr, write data, read addr
    int err_total, n_checks, cyc, rises;

    two_channel_dma_controller u_two_channel_dma_controller (
        .i_clock(clock), .i_srst(srst), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata), .i_dreq(dreq), .o_irq(irq),
        .o_bus_req(bus_req), .i_bus_grant(grant), .o_mem_addr(mem_addr),
        .o_mem_rd(mem_rd), .o_mem_wr(mem_wr), .o_mem_size(mem_size),
        .o_mem_wdata(mem_wdata), .i_mem_rdata(mem_rdata),
        .i_mem_ack(mem_ack), .i_mem_err(mem_err));
    bus_partner u_bus_partner (
        .i_clock(clock), .i_srst(srst), .i_bus_req(bus_req),
        .o_bus_grant(grant), .i_mem_addr(mem_addr), .i_mem_rd(mem_rd),
        .i_mem_wr(mem_wr), .o_mem_rdata(mem_rdata), .o_mem_ack(mem_ack),
        .o_mem_err(mem_err), .i_slow(slow), .i_fail(fail));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    // Traffic log, request rises and hang limit
    always @(posedge clock) begin
        if (mem_wr && mem_ack) begin
            wq.push_back(mem_addr);
            dq.push_back(mem_wdata);
            zs = mem_size;
        end
        if (mem_rd && mem_ack) rq.push_back(mem_addr);
        if (bus_req && !req_q) rises++;
        req_q = bus_req;
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // Poll status until done or error shows
    task automatic wait_end(input logic [7:0] b);
        for (int k = 0; k < 300; k++) begin
            rd(b + dma_pkg::OFF_STATUS, s);
            if (s[1:0] != 2'h0) return;
        end
        check(s[1:0] != 2'h0, 1'b1);
    endtask : wait_end

    task automatic setup(input logic [7:0] b, input logic [31:0] c, sa, da, n);
        wr(b + dma_pkg::OFF_SRC, sa);
        wr(b + dma_pkg::OFF_DST, da);
        wr(b + dma_pkg::OFF_COUNT, n);
        wr(b + dma_pkg::OFF_CTRL, c);
    endtask : setup

    // Clear flags, logs and request count
    task automatic clr();
        wr(dma_pkg::OFF_STATUS, 32'h3);
        wr(C1 + dma_pkg::OFF_STATUS, 32'h3);
        wq = {};
        dq = {};
        rq = {};
        rises = 0;
    endtask : clr

    // Three word moves, cycle steal, software start
    task automatic t_steal();
        clr();
        setup(8'h00, 32'h5, 32'h100, 32'h200, 32'h2);
        wr(dma_pkg::OFF_SWREQ, 32'h1);
        wait_end(8'h00);
        check(s[1:0], 32'h1);
        check(wq.size(), 3);
        check(wq[2], 32'h208);
        check(dq[2], 32'h5a5a_a4ad);
        check(zs, dma_pkg::SIZE_WORD);
        check(rises, 3);
        check(irq, 2'h1);
        rd(dma_pkg::OFF_CTRL, s);
        check(s[0], 1'b0);
    endtask : t_steal

    // Burst, fixed source, half-words, external start, masked
    task automatic t_burst();
        clr();
        slow <= 1'b1;
        dreq <= 2'h2;
        setup(C1, 32'heb, 32'h300, 32'h400, 32'h1);
        wait_end(C1);
        check(rises, 1);
        check(rq[1], 32'h300);
        check(wq[1], 32'h402);
        check(zs, dma_pkg::SIZE_HALF);
        check(irq, 2'h0);
        check(s[0], 1'b1);
        repeat (20) @(posedge clock);
        check(wq.size(), 2);
        dreq <= 2'h0;
        slow <= 1'b0;
    endtask : t_burst

    // Both channels requested together
    task automatic both(input logic [31:0] first);
        clr();
        setup(8'h00, 32'h45, 32'h500, 32'h600, 32'h0);
        setup(C1, 32'h45, 32'h700, 32'h800, 32'h0);
        dreq <= 2'h3;
        wait_end(8'h00);
        wait_end(C1);
        dreq <= 2'h0;
        check(wq[0], first);
        check(wq.size(), 2);
    endtask : both

    // Read error ends job, flagged on own line only
    task automatic t_err();
        clr();
        fail <= 1'b1;
        setup(8'h00, 32'h5, 32'h900, 32'ha00, 32'h3);
        wr(dma_pkg::OFF_SWREQ, 32'h1);
        wait_end(8'h00);
        fail <= 1'b0;
        check(s[1:0], 32'h2);
        check(wq.size(), 0);
        check(irq, 2'h1);
        wr(dma_pkg::OFF_STATUS, 32'h2);
        rd(8'h80, s);
        check(irq, 2'h0);
        check(s, 32'h0);
    endtask : t_err

    // Round-robin on, channel zero served once to set the last grant
    task automatic t_prime();
        wr(dma_pkg::OFF_PRIO, 32'h1);
        rd(dma_pkg::OFF_PRIO, s);
        check(s, 32'h1);
        clr();
        setup(8'h00, 32'h5, 32'h100, 32'h200, 32'h0);
        wr(dma_pkg::OFF_SWREQ, 32'h1);
        wait_end(8'h00);
        check(wq[0], 32'h200);
    endtask : t_prime

    // Bytes to a fixed I/O side, illegal size, full-range count
    task automatic t_byte();
        clr();
        setup(8'h00, 32'h11, 32'hb00, 32'hc00, 32'h1);
        wr(dma_pkg::OFF_SWREQ, 32'h1);
        wait_end(8'h00);
        check(wq[1], 32'hc00);
        check(rq[1], 32'hb01);
        check(zs, dma_pkg::SIZE_BYTE);
        clr();
        setup(8'h00, 32'h7, 32'hb00, 32'hc00, 32'h0);
        wr(dma_pkg::OFF_SWREQ, 32'h1);
        wait_end(8'h00);
        check(s[1:0], 32'h2);
        check(wq.size(), 0);
        wr(C1 + dma_pkg::OFF_COUNT, 32'h1_ffff);
        rd(C1 + dma_pkg::OFF_COUNT, s);
        check(s, 32'hffff);
    endtask : t_byte

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////
    // Reset, then each scenario in turn
    initial begin
        {srst, reg_wr, reg_rd, slow, fail, req_q} = 6'h21;
        {reg_addr, reg_wdata, dreq} = '0;
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        t_steal();
        t_burst();
        both(32'h600);
        t_prime();
        both(32'h800);
        t_byte();
        t_err();
        end_sim();
    end
endmodule : tb
